// >>> hw/fault_status_and_handler_active.sv
// Fault cause status, handler active flags and fault addresses behind Avalon-MM
`include "fault_status_cfg.svh"

module fault_status_and_handler_active
	import fault_status_pkg::*;
(
	input  wire logic               clk_sys,           // Processor clock
	input  wire logic               rstn,              // Synchronous reset, active low
	input  wire logic               ce,                // Clock enable, freezes state when low
	input  wire logic [`ADDR_W-1:0] address,           // Byte address
	input  wire logic [3:0]         byteenable,        // Byte lanes
	input  wire logic               read,              // Read request
	input  wire logic               write,             // Write request
	input  wire logic [31:0]        writedata,         // Write data
	input  wire logic               privileged,        // Access comes from privileged code
	output logic      [31:0]        readdata,          // Read data
	output logic                    waitrequest,       // Stall, low for one answer cycle
	input  wire logic [31:0]        causeSet,          // Fault cause pulses from the core
	input  wire logic [3:0]         activeSet,         // Exception entry, svc/usg/bus/mem
	input  wire logic [3:0]         activeClear,       // Exception return, same order
	input  wire logic               memAddrLoad,       // Capture memory fault address
	input  wire logic [31:0]        memAddrIn,         // Memory fault address
	input  wire logic               busAddrLoad,       // Capture bus fault address
	input  wire logic [31:0]        busAddrIn,         // Bus fault address
	output logic                    memmgmtFaultActive,  // Active flag
	output logic                    busFaultActive,      // Active flag
	output logic                    usageFaultActive,    // Active flag
	output logic                    supervisorCallActive, // Active flag
	output logic                    irq                // Level interrupt
);

	// --------------------------------------------------------------
	// Decode helpers
	// --------------------------------------------------------------

	// Byte lanes turned into a bit mask
	function automatic word_t laneMask(input logic [3:0] be);
		word_t m;
		m = '0;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{be[i]}};
		end
		return m;
	endfunction

	// Word-aligned match of an offset
	function automatic logic hitWord(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] o);
		return a[`ADDR_W-1:2] == o[`ADDR_W-1:2];
	endfunction

	// --------------------------------------------------------------
	// State
	// --------------------------------------------------------------
	bus_state_t       busState_reg;    // Handshake state
	word_t            faultCause_reg;  // Usage 31:16, bus 15:8, memory 7:0
	word_t            faultCause_next; // Next cause value
	word_t            memAddr_reg;     // Memory fault address
	word_t            busAddr_reg;     // Bus fault address
	logic [`EVT_W-1:0] evtStat_reg;    // Sticky interrupt events
	logic [`EVT_W-1:0] evtMask_reg;    // Interrupt enables
	logic [`EVT_W-1:0] evtRaise;       // New events this cycle
	word_t            readNext;        // Read value for the answer
	word_t            wrMask;          // Enabled write lanes
	logic             accept;          // Request completes this edge
	logic             wrOk;            // Privileged write completing
	logic             unpriv;          // Unprivileged access
	logic             hitFault;        // Fault status word selected
	logic             hitHandler;      // Handler active word selected

	// --------------------------------------------------------------
	// Request decode
	// --------------------------------------------------------------
	always_comb begin
		accept     = (read || write) && !waitrequest;
		unpriv     = !privileged;
		wrOk       = accept && write && privileged;
		wrMask     = laneMask(byteenable);
		hitFault   = hitWord(address, `OFS_FAULT);
		hitHandler = hitWord(address, `OFS_HANDLER);
	end

	// --------------------------------------------------------------
	// Read mux, only selected lanes carry data
	// --------------------------------------------------------------
	always_comb begin
		readNext = '0;
		if (unpriv) begin
			// Unprivileged reads see zero
			readNext = '0;
		end else if (hitFault) begin
			readNext = faultCause_reg & laneMask(byteenable);
		end else if (hitHandler) begin
			// Reserved bits 6:4 and 2 stay zero
			readNext[`BIT_SVC_ACT] = supervisorCallActive & byteenable[0];
			readNext[`BIT_USG_ACT] = usageFaultActive & byteenable[0];
			readNext[`BIT_BUS_ACT] = busFaultActive & byteenable[0];
			readNext[`BIT_MEM_ACT] = memmgmtFaultActive & byteenable[0];
		end else if (hitWord(address, `OFS_MEM_ADDR)) begin
			readNext = memAddr_reg & laneMask(byteenable);
		end else if (hitWord(address, `OFS_BUS_ADDR)) begin
			readNext = busAddr_reg & laneMask(byteenable);
		end else if (hitWord(address, `OFS_IRQ_STAT)) begin
			readNext[`EVT_W-1:0] = evtStat_reg & {`EVT_W{byteenable[0]}};
		end else if (hitWord(address, `OFS_IRQ_MASK)) begin
			readNext[`EVT_W-1:0] = evtMask_reg & {`EVT_W{byteenable[0]}};
		end else begin
			// Unmapped addresses read zero, writes dropped
			readNext = '0;
		end
	end

	// --------------------------------------------------------------
	// Avalon handshake: one wait cycle, then a single answer cycle
	// --------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			busState_reg <= BUS_IDLE;
			waitrequest  <= 1'b1;
			readdata     <= '0;
		end else if (ce) begin
			case (busState_reg)
				BUS_IDLE: begin
					// Data captured now; master holds the request stable
					if (read || write) begin
						busState_reg <= BUS_ANSWER;
						waitrequest  <= 1'b0;
						readdata     <= read ? readNext : '0;
					end
				end
				BUS_ANSWER: begin
					// Request retires on this edge
					busState_reg <= BUS_IDLE;
					waitrequest  <= 1'b1;
				end
				default: begin
					busState_reg <= BUS_IDLE;
					waitrequest  <= 1'b1;
				end
			endcase
		end
	end

	// --------------------------------------------------------------
	// Fault cause status: sticky, write-one-to-clear, set wins
	// --------------------------------------------------------------
	always_comb begin
		faultCause_next = faultCause_reg;
		if (wrOk && hitFault) begin
			// Zero bits and unselected lanes keep their value
			faultCause_next = faultCause_reg & ~(writedata & wrMask);
		end
		faultCause_next = faultCause_next | causeSet;
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			faultCause_reg <= `RST_FAULT;
		end else if (ce) begin
			faultCause_reg <= faultCause_next;
		end
	end

	// --------------------------------------------------------------
	// Fault addresses: latest capture wins
	// --------------------------------------------------------------
	// A preempting fault overwrites the saved value, so the handler
	// must copy the address before it trusts the valid flag.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			memAddr_reg <= '0;
			busAddr_reg <= '0;
		end else if (ce) begin
			if (memAddrLoad) begin
				memAddr_reg <= memAddrIn;
			end
			if (busAddrLoad) begin
				busAddr_reg <= busAddrIn;
			end
		end
	end

	// --------------------------------------------------------------
	// Handler active flags: core entry/exit beats a software write
	// --------------------------------------------------------------
	// Software may force these; doing so without a matching exception
	// corrupts the return sequence, so drivers should avoid it.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			{supervisorCallActive, usageFaultActive, busFaultActive, memmgmtFaultActive}
				<= `RST_ACTIVE;
		end else if (ce) begin
			if (wrOk && hitHandler && byteenable[0]) begin
				supervisorCallActive <= writedata[`BIT_SVC_ACT];
				usageFaultActive     <= writedata[`BIT_USG_ACT];
				busFaultActive       <= writedata[`BIT_BUS_ACT];
				memmgmtFaultActive   <= writedata[`BIT_MEM_ACT];
			end
			// Hardware events override, set over clear
			if (activeClear[3]) supervisorCallActive <= 1'b0;
			if (activeClear[2]) usageFaultActive <= 1'b0;
			if (activeClear[1]) busFaultActive <= 1'b0;
			if (activeClear[0]) memmgmtFaultActive <= 1'b0;
			if (activeSet[3]) supervisorCallActive <= 1'b1;
			if (activeSet[2]) usageFaultActive <= 1'b1;
			if (activeSet[1]) busFaultActive <= 1'b1;
			if (activeSet[0]) memmgmtFaultActive <= 1'b1;
		end
	end

	// --------------------------------------------------------------
	// Interrupt events: one per subregister
	// --------------------------------------------------------------
	always_comb begin
		evtRaise = '0;
		evtRaise[`EVT_MEM] = |causeSet[7:0];
		evtRaise[`EVT_BUS] = |causeSet[15:8];
		evtRaise[`EVT_USG] = |causeSet[31:16];
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			evtStat_reg <= `RST_EVT;
		end else if (ce) begin
			if (wrOk && hitWord(address, `OFS_IRQ_STAT) && byteenable[0]) begin
				evtStat_reg <= (evtStat_reg & ~writedata[`EVT_W-1:0]) | evtRaise;
			end else begin
				evtStat_reg <= evtStat_reg | evtRaise;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			evtMask_reg <= `RST_EVT;
		end else if (ce && wrOk && hitWord(address, `OFS_IRQ_MASK) && byteenable[0]) begin
			evtMask_reg <= writedata[`EVT_W-1:0];
		end
	end

	// Registered level, one cycle behind the status
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			irq <= 1'b0;
		end else if (ce) begin
			irq <= |(evtStat_reg & evtMask_reg);
		end
	end

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	sequence s_request;
		ce && (read || write) && waitrequest && busState_reg == BUS_IDLE;
	endsequence

	sequence s_answer;
		!waitrequest ##1 waitrequest;
	endsequence

	a_bus_answer_timing: assert property (s_request |=> s_answer)
		else $error("answer not one cycle after request");

	a_usage_active_set: assert property (ce && activeSet[2] |=> usageFaultActive)
		else $error("usage active flag not set by entry");

	a_bus_active_clear: assert property (
		ce && activeClear[1] && !activeSet[1] |=> !busFaultActive)
		else $error("bus active flag not cleared by return");

	a_mem_active_write: assert property (
		ce && wrOk && hitHandler && byteenable[0] && activeSet == 4'h0 && activeClear == 4'h0
		|=> memmgmtFaultActive == $past(writedata[`BIT_MEM_ACT]))
		else $error("memory active flag ignored write");

	a_svc_read_back: assert property (
		s_request ##0 (read && privileged && hitHandler && byteenable[0])
		|=> readdata[`BIT_SVC_ACT] == $past(supervisorCallActive))
		else $error("svc active flag read wrong");

	a_reserved_zero: assert property (
		s_request ##0 (read && hitHandler) |=> readdata[6:4] == 3'h0 && !readdata[2])
		else $error("reserved handler bits not zero");

	a_cause_sticky: assert property (
		ce && |causeSet |=> (faultCause_reg & $past(causeSet)) == $past(causeSet))
		else $error("fault cause not recorded");

	a_bus_byte_lane: assert property (
		s_request ##0 (read && privileged && hitFault && byteenable == 4'h2)
		|=> readdata == {16'h0000, $past(faultCause_reg[15:8]), 8'h00})
		else $error("bus byte lane read wrong");

	a_w1c_clear: assert property (
		ce && wrOk && hitFault && causeSet == 32'h0
		|=> faultCause_reg == ($past(faultCause_reg) & ~($past(writedata) & $past(wrMask))))
		else $error("write one did not clear");

	a_unpriv_blocked: assert property (
		ce && accept && unpriv && causeSet == 32'h0 |=> $stable(faultCause_reg))
		else $error("unprivileged write changed status");

	a_addr_overwrite: assert property (ce && busAddrLoad |=> busAddr_reg == $past(busAddrIn))
		else $error("bus fault address not overwritten");

	a_reset_zero: assert property (
		@(posedge clk_sys) disable iff (1'b0) !rstn |=> faultCause_reg == 32'h0)
		else $error("status not zero after reset");

endmodule

// >>> common/fault_status_cfg.svh
// Bus geometry, offsets, field positions and reset values of the fault status block
`ifndef FAULT_STATUS_CFG_SVH
`define FAULT_STATUS_CFG_SVH

// --------------------------------------------------------------
// Bus geometry
// --------------------------------------------------------------
`define ADDR_W          12
`define DATA_W          32

// --------------------------------------------------------------
// Register offsets (byte addresses)
// --------------------------------------------------------------
`define OFS_HANDLER     12'hD24
`define OFS_FAULT       12'hD28
`define OFS_MEM_BYTE    12'hD28
`define OFS_BUS_BYTE    12'hD29
`define OFS_USAGE_HALF  12'hD2A
`define OFS_MEM_ADDR    12'hD34
`define OFS_BUS_ADDR    12'hD38
`define OFS_IRQ_STAT    12'hD40
`define OFS_IRQ_MASK    12'hD44

// --------------------------------------------------------------
// Field positions
// --------------------------------------------------------------
`define BIT_MEM_ACT     0
`define BIT_BUS_ACT     1
`define BIT_USG_ACT     3
`define BIT_SVC_ACT     7
`define BIT_MEM_VALID   7
`define BIT_BUS_VALID   15
`define EVT_MEM         0
`define EVT_BUS         1
`define EVT_USG         2
`define EVT_W           3

// --------------------------------------------------------------
// Reset values
// --------------------------------------------------------------
`define RST_FAULT       32'h0000_0000
`define RST_ACTIVE      4'h0
`define RST_EVT         3'h0

`endif

// >>> common/fault_status_pkg.sv
// Types shared by the fault status block
package fault_status_pkg;

	// --------------------------------------------------------------
	// Bus handshake states
	// --------------------------------------------------------------
	typedef enum logic {
		BUS_IDLE,   // Waiting for a request
		BUS_ANSWER  // Answer presented, waitrequest low
	} bus_state_t;

	typedef logic [31:0] word_t; // One register word

endpackage

// >>> test/fault_status_and_handler_active_test.sv
// Self-checking bench for the fault status and handler active block
`include "fault_status_cfg.svh"

module fault_status_and_handler_active_test
	import fault_status_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------------------------
	logic               clk_sys      = 1'b0;  // 20 MHz processor clock
	logic               rstn         = 1'b0;  // Synchronous reset, active low
	logic               ce           = 1'b1;  // Dropped once, bus idle, to freeze state
	logic [`ADDR_W-1:0] address      = '0;    // Bus byte address
	logic [3:0]         byteenable   = 4'h0;  // Bus byte lanes
	logic               read         = 1'b0;  // Bus read request
	logic               write        = 1'b0;  // Bus write request
	word_t              writedata    = '0;    // Bus write data
	logic               privileged   = 1'b1;  // Access level of the request
	word_t              causeSet     = '0;    // Core fault cause pulses
	logic [3:0]         activeSet    = 4'h0;  // Core exception entry
	logic [3:0]         activeClear  = 4'h0;  // Core exception return
	logic               memAddrLoad  = 1'b0;  // Memory address capture
	word_t              memAddrIn    = '0;    // Memory address value
	logic               busAddrLoad  = 1'b0;  // Bus address capture
	word_t              busAddrIn    = '0;    // Bus address value
	word_t              readdata;             // Bus read data
	logic               waitrequest;          // Bus stall
	logic [3:0]         actFlags;             // svc, usage, bus, mem flags
	logic               irq;                  // Level interrupt
	int                 failures     = 0;     // Mismatch count
	int                 comparisons  = 0;     // Compare count

	fault_status_and_handler_active dut (
		.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .address(address),
		.byteenable(byteenable), .read(read), .write(write), .writedata(writedata),
		.privileged(privileged), .readdata(readdata), .waitrequest(waitrequest),
		.causeSet(causeSet), .activeSet(activeSet), .activeClear(activeClear),
		.memAddrLoad(memAddrLoad), .memAddrIn(memAddrIn), .busAddrLoad(busAddrLoad),
		.busAddrIn(busAddrIn), .memmgmtFaultActive(actFlags[0]),
		.busFaultActive(actFlags[1]), .usageFaultActive(actFlags[2]),
		.supervisorCallActive(actFlags[3]), .irq(irq));

	// Free-running clock, 50 ns period
	always #25 clk_sys = ~clk_sys;

	// ----------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------
	// Verdict and end of run, single exit point
	task automatic test_done();
		if (failures == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Compare with case equality so unknowns never match
	task automatic check(input word_t got, input word_t exp, input string what);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	// One Avalon transfer, held until waitrequest is sampled low
	task automatic busDo(input logic rd, input logic [`ADDR_W-1:0] a, input logic [3:0] be,
		input word_t d, input logic priv, output word_t q);
		@(posedge clk_sys);
		read       <= rd;
		write      <= !rd;
		address    <= a;
		byteenable <= be;
		writedata  <= d;
		privileged <= priv;
		// No cycle count assumed; a hang is ended by the watchdog only
		do begin
			@(posedge clk_sys);
		end while (waitrequest !== 1'b0);
		q = readdata;
		read  <= 1'b0;
		write <= 1'b0;
	endtask

	// Privileged read with expected value
	task automatic rdChk(input logic [`ADDR_W-1:0] a, input logic [3:0] be, input word_t exp);
		word_t q;
		busDo(1'b1, a, be, '0, 1'b1, q);
		check(q, exp, "register read");
	endtask

	// Privileged write
	task automatic wr(input logic [`ADDR_W-1:0] a, input logic [3:0] be, input word_t d);
		word_t q;
		busDo(1'b0, a, be, d, 1'b1, q);
	endtask

	// Core-side pulse, then time for status and interrupt to settle
	task automatic core(input word_t c, input logic [3:0] s, input logic [3:0] k);
		@(posedge clk_sys);
		causeSet    <= c;
		activeSet   <= s;
		activeClear <= k;
		@(posedge clk_sys);
		causeSet    <= '0;
		activeSet   <= 4'h0;
		activeClear <= 4'h0;
		repeat (3) @(posedge clk_sys);
	endtask

	// Capture both fault addresses in one pulse
	task automatic loadAddr(input word_t m, input word_t b);
		@(posedge clk_sys);
		memAddrLoad <= 1'b1;
		busAddrLoad <= 1'b1;
		memAddrIn   <= m;
		busAddrIn   <= b;
		@(posedge clk_sys);
		memAddrLoad <= 1'b0;
		busAddrLoad <= 1'b0;
		memAddrIn   <= ~m;  // Stale value must not be captured again
		busAddrIn   <= ~b;
	endtask

	// ----------------------------------------------------------
	// Watchdog, far beyond the few hundred cycles the tests need
	// ----------------------------------------------------------
	initial begin
		repeat (5000) @(posedge clk_sys);
		failures++;
		test_done();
	end

	// ----------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------
	initial begin
		word_t q;
		repeat (16) @(posedge clk_sys);
		rstn <= 1'b1;
		rdChk(`OFS_FAULT, 4'hF, `RST_FAULT);
		rdChk(`OFS_HANDLER, 4'hF, 32'h0000_0000);
		// Software sets every bit, only the four flags stick
		wr(`OFS_HANDLER, 4'hF, 32'hFFFF_FFFF);
		rdChk(`OFS_HANDLER, 4'hF, 32'h0000_008B);
		check({28'h0, actFlags}, 32'h0000_000F, "active outputs");
		wr(`OFS_HANDLER, 4'hF, 32'h0000_0080);
		rdChk(`OFS_HANDLER, 4'hF, 32'h0000_0080);
		// Hardware return clears all, entry sets usage and memory
		core('0, 4'h0, 4'hF);
		rdChk(`OFS_HANDLER, 4'hF, 32'h0000_0000);
		core('0, 4'h5, 4'h0);
		rdChk(`OFS_HANDLER, 4'hF, 32'h0000_0009);
		check({28'h0, actFlags}, 32'h0000_0005, "active outputs");
		// Causes in all three subregisters, bus event unmasked
		wr(`OFS_IRQ_MASK, 4'hF, 32'h0000_0002);
		core(32'h030C_8181, 4'h0, 4'h0);
		rdChk(`OFS_IRQ_STAT, 4'hF, 32'h0000_0007);
		check({31'h0, irq}, 32'h0000_0001, "irq unmasked");
		wr(`OFS_IRQ_MASK, 4'hF, 32'h0000_0000);
		repeat (3) @(posedge clk_sys);
		check({31'h0, irq}, 32'h0000_0000, "irq masked");
		wr(`OFS_IRQ_MASK, 4'hF, 32'h0000_0007);
		wr(`OFS_IRQ_STAT, 4'hF, 32'h0000_0002);
		rdChk(`OFS_IRQ_STAT, 4'hF, 32'h0000_0005);
		check({31'h0, irq}, 32'h0000_0001, "irq still pending");
		wr(`OFS_IRQ_STAT, 4'hF, 32'h0000_0005);
		repeat (3) @(posedge clk_sys);
		check({31'h0, irq}, 32'h0000_0000, "irq cleared");
		// Subregister views of the same word
		rdChk(`OFS_FAULT, 4'hF, 32'h030C_8181);
		rdChk(`OFS_MEM_BYTE, 4'h1, 32'h0000_0081);
		rdChk(`OFS_FAULT, 4'h3, 32'h0000_8181);
		rdChk(`OFS_BUS_BYTE, 4'h2, 32'h0000_8100);
		rdChk(`OFS_USAGE_HALF, 4'hC, 32'h030C_0000);
		// Unprivileged access reads zero and cannot clear
		busDo(1'b1, `OFS_FAULT, 4'hF, '0, 1'b0, q);
		check(q, 32'h0000_0000, "unprivileged read");
		busDo(1'b0, `OFS_FAULT, 4'hF, 32'hFFFF_FFFF, 1'b0, q);
		rdChk(`OFS_FAULT, 4'hF, 32'h030C_8181);
		// Clear by lane, zeros and unselected lanes untouched
		wr(`OFS_FAULT, 4'hF, 32'h0000_0000);
		rdChk(`OFS_FAULT, 4'hF, 32'h030C_8181);
		wr(`OFS_BUS_BYTE, 4'h2, 32'hFFFF_FFFF);
		rdChk(`OFS_FAULT, 4'hF, 32'h030C_0081);
		wr(`OFS_USAGE_HALF, 4'hC, 32'h0100_0000);
		rdChk(`OFS_FAULT, 4'hF, 32'h020C_0081);
		wr(`OFS_MEM_BYTE, 4'h1, 32'hFFFF_FFFF);
		rdChk(`OFS_FAULT, 4'hF, 32'h020C_0000);
		wr(`OFS_FAULT, 4'hF, 32'hFFFF_FFFF);
		rdChk(`OFS_FAULT, 4'hF, 32'h0000_0000);
		rdChk(12'hF00, 4'hF, 32'h0000_0000);
		// Handler order: save address first, then trust valid flag
		loadAddr(32'h2000_1234, 32'h4000_5678);
		core(32'h0000_8080, 4'h0, 4'h0);
		rdChk(`OFS_MEM_ADDR, 4'hF, 32'h2000_1234);
		rdChk(`OFS_BUS_ADDR, 4'hF, 32'h4000_5678);
		rdChk(`OFS_FAULT, 4'h3, 32'h0000_8080);
		// Preempting fault replaces the stored addresses
		loadAddr(32'h2000_ABCD, 32'h4000_EF01);
		rdChk(`OFS_MEM_ADDR, 4'hF, 32'h2000_ABCD);
		rdChk(`OFS_BUS_ADDR, 4'hF, 32'h4000_EF01);
		// Clock enable low: core pulses must not land anywhere
		ce <= 1'b0;
		core(32'h0000_0001, 4'h2, 4'h0);
		ce <= 1'b1;
		rdChk(`OFS_FAULT, 4'hF, 32'h0000_8080);
		check({28'h0, actFlags}, 32'h0000_0005, "active frozen");
		// Reset in mid-run with status and flags set
		rstn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		rdChk(`OFS_FAULT, 4'hF, `RST_FAULT);
		rdChk(`OFS_HANDLER, 4'hF, 32'h0000_0000);
		check({28'h0, actFlags}, 32'h0000_0000, "active after reset");
		rdChk(`OFS_IRQ_STAT, 4'hF, 32'h0000_0000);
		test_done();
	end

endmodule
